// [shared/mer_defs.vh]
`ifndef MER_DEFS_VH
`define MER_DEFS_VH

// Register word offsets (byte addresses)
`define MER_OFS_CTRL    8'h00
`define MER_OFS_GATE    8'h04
`define MER_OFS_STAT    8'h08
`define MER_OFS_CMD     8'h0c
`define MER_OFS_WDOG    8'h10
`define MER_OFS_PPORT   8'h14
`define MER_OFS_STATE   8'h18

// Control register fields
`define MER_C_ACPI_GATE  0
`define MER_C_MGMT_GATE  1
`define MER_C_DONE       2
`define MER_C_APIC       3
`define MER_C_ROUTE_LO   4
`define MER_C_ROUTE_HI   6
`define MER_C_NMI_GATE   7
`define MER_C_CHAS_LO    8
`define MER_C_CHAS_HI    9
`define MER_C_LOCK       10
`define MER_C_UNPROT     11
`define MER_C_PINLOCK    12
`define MER_CTRL_W       13
`define MER_CTRL_RST     13'h0004
`define MER_CHAS_SMI     2'h2

// Gate register fields
`define MER_G_FWREL      0
`define MER_G_OSREL      1
`define MER_G_PPORT      2
`define MER_G_SLEEP      3
`define MER_G_PINUNL     4
`define MER_G_PME        5
`define MER_G_HP_ACPI    6
`define MER_G_HP_MGMT    7
`define MER_G_HNOTE      8
`define MER_G_ESPI_ACPI  9
`define MER_G_ESPI_MGMT  10
`define MER_GATE_W       11
`define MER_GATE_RST     11'h000

// Command register fields (write only)
`define MER_K_FWREL      0
`define MER_K_OSREL      1
`define MER_K_SLEEP      2

// Status flag positions
`define MER_F_FWREL      0
`define MER_F_OSREL      1
`define MER_F_CPUWD      2
`define MER_F_OSWD       3
`define MER_F_WDOG       4
`define MER_F_NMI        5
`define MER_F_CHAS       6
`define MER_F_FLASH      7
`define MER_F_PPORT      8
`define MER_F_SLEEP      9
`define MER_F_PINUNL     10
`define MER_F_PME        11
`define MER_F_HP         12
`define MER_F_IOTRAP     13
`define MER_F_SMB        14
`define MER_F_HNOTE      15
`define MER_F_ESPI       16
`define MER_F_BTNOVR     17
`define MER_FLAG_W       18

// Timing
`define MER_CLK_MHZ      100
`define MER_ESPI_HOLD_US 100

`endif

// [design/mer_sync.v]
`timescale 1ns/100ps
`default_nettype none

// Two-flop synchroniser for asynchronous pins
module mer_sync #(
  parameter       W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         ref_clk,
  input  wire         arst_n,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_r;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r   <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // mer_sync

`default_nettype wire

// [design/mer_flags.v]
`timescale 1ns/100ps
`default_nettype none

// Sticky status flags, write-one-to-clear; a set in the clear cycle wins
module mer_flags #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         arst_n,
  input  wire [W-1:0] set_in,
  input  wire [W-1:0] clr_in,
  output reg  [W-1:0] flag_r
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_flag
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
          flag_r[i] <= 1'b0;
        else if (set_in[i])
          flag_r[i] <= 1'b1;
        else if (clr_in[i])
          flag_r[i] <= 1'b0;
      end
    end
  endgenerate

endmodule // mer_flags

`default_nettype wire

// [design/mer_top.v]
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "mer_defs.vh"

module mer_top #(
  parameter ESPI_HOLD_CYC = `MER_ESPI_HOLD_US * `MER_CLK_MHZ
) (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        chassis_open_in_n,
  input  wire        smbus_alert_n,
  input  wire        espi_acpi_req,
  input  wire        nmi_in,
  input  wire        pme_msg,
  input  wire        hotplug_msg,
  input  wire        cpu_watchdog_msg,
  input  wire        io_trap_hit,
  input  wire        host_notify_msg,
  input  wire        flash_write_try,
  input  wire        button_override,
  input  wire        wake_to_s0,
  output reg         mgmt_mode_interrupt,
  output reg         acpi_level_irq,
  output reg  [6:0]  acpi_irq_line,
  output reg         enter_s5,
  output reg         pme_wake
);

  // One-hot over lines 9,10,11,20,21,22,23; high lines need APIC mode
  function [6:0] line_dec;
    input [2:0] sel;
    input       apic;
    begin
      if (sel > 3'h6 || (sel > 3'h2 && !apic))
        line_dec = 7'h01;
      else
        line_dec = 7'h01 << sel;
    end
  endfunction

  wire [3:0] pin_s;
  reg  [3:0] pin_d_r;
  wire       nmi_s   = pin_s[3];
  wire       espi_s  = pin_s[2];
  wire       smb_a   = ~pin_s[1];
  wire       chas_a  = ~pin_s[0];
  wire [3:0] pin_act = {nmi_s, espi_s, smb_a, chas_a};
  wire [3:0] pin_rise = pin_act & ~{pin_d_r[3:2], ~pin_d_r[1:0]};

  mer_sync #(
    .W    (4),
    .INIT (4'h3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .async_in ({nmi_in, espi_acpi_req, smbus_alert_n, chassis_open_in_n}),
    .sync_out (pin_s)
  );

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      pin_d_r <= 4'h3;
    else
      pin_d_r <= pin_s;
  end

  reg [`MER_CTRL_W-1:0] ctrl_r;
  reg [`MER_GATE_W-1:0] gate_r;
  reg [7:0]             wdog_r;
  reg [7:0]             pport_r;
  reg                   done_r;
  reg                   ovr_awake_r;
  reg [13:0]            espi_cnt_r;
  reg                   espi_seen_r;
  wire [`MER_FLAG_W-1:0] flag;

  // One decode for every register write strobe
  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = wr && addr == ofs;
    end
  endfunction

  wire wr_ctrl  = wr_hit(reg_wr, reg_addr, `MER_OFS_CTRL);
  wire wr_gate  = wr_hit(reg_wr, reg_addr, `MER_OFS_GATE);
  wire wr_stat  = wr_hit(reg_wr, reg_addr, `MER_OFS_STAT);
  wire wr_cmd   = wr_hit(reg_wr, reg_addr, `MER_OFS_CMD);
  wire wr_wdog  = wr_hit(reg_wr, reg_addr, `MER_OFS_WDOG);
  wire wr_pport = wr_hit(reg_wr, reg_addr, `MER_OFS_PPORT);

  wire acpi_gate = ctrl_r[`MER_C_ACPI_GATE];
  wire mgmt_gate = ctrl_r[`MER_C_MGMT_GATE];

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r  <= `MER_CTRL_RST;
      gate_r  <= `MER_GATE_RST;
      wdog_r  <= 8'h00;
      pport_r <= 8'h00;
    end else begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata[`MER_CTRL_W-1:0];
      if (wr_gate)
        gate_r <= reg_wdata[`MER_GATE_W-1:0];
      if (wr_wdog)
        wdog_r <= reg_wdata[7:0];
      if (wr_pport)
        pport_r <= reg_wdata[7:0];
    end
  end

  // qualify eSPI hold time
  // Request must stay high the full hold time; shorter pulses are dropped
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      espi_cnt_r  <= 14'h0000;
      espi_seen_r <= 1'b0;
    end else if (!espi_s) begin
      espi_cnt_r  <= 14'h0000;
      espi_seen_r <= 1'b0;
    end else if (espi_cnt_r < ESPI_HOLD_CYC[13:0] - 14'h0001) begin
      espi_cnt_r <= espi_cnt_r + 14'h0001;
    end else begin
      espi_seen_r <= 1'b1;
    end
  end

  wire espi_evt = espi_s && !espi_seen_r && espi_cnt_r == ESPI_HOLD_CYC[13:0] - 14'h0001;

  reg [`MER_FLAG_W-1:0] set_v;

  always @* begin
    set_v = {`MER_FLAG_W{1'b0}};
    set_v[`MER_F_FWREL] = wr_cmd && reg_wdata[`MER_K_FWREL];
    set_v[`MER_F_OSREL] = wr_cmd && reg_wdata[`MER_K_OSREL];
    set_v[`MER_F_CPUWD] = cpu_watchdog_msg;
    set_v[`MER_F_OSWD]  = wr_wdog;
    set_v[`MER_F_NMI]   = pin_rise[3] && ctrl_r[`MER_C_NMI_GATE];
    set_v[`MER_F_WDOG]  = set_v[`MER_F_NMI];
    set_v[`MER_F_CHAS]  = pin_rise[0] && ctrl_r[`MER_C_CHAS_HI:`MER_C_CHAS_LO] == `MER_CHAS_SMI;
    set_v[`MER_F_FLASH] = (wr_ctrl && ctrl_r[`MER_C_LOCK] && !ctrl_r[`MER_C_UNPROT] &&
                           reg_wdata[`MER_C_UNPROT]) ||
                          (flash_write_try && !ctrl_r[`MER_C_UNPROT]);
    set_v[`MER_F_PPORT] = wr_pport;
    set_v[`MER_F_SLEEP] = wr_cmd && reg_wdata[`MER_K_SLEEP];
    set_v[`MER_F_PINUNL] = wr_ctrl && ctrl_r[`MER_C_PINLOCK] && !reg_wdata[`MER_C_PINLOCK];
    set_v[`MER_F_PME]   = pme_msg;
    set_v[`MER_F_HP]    = hotplug_msg;
    set_v[`MER_F_IOTRAP] = io_trap_hit;
    set_v[`MER_F_SMB]   = pin_rise[1] || host_notify_msg;
    set_v[`MER_F_HNOTE] = host_notify_msg;
    set_v[`MER_F_ESPI]  = espi_evt;
    set_v[`MER_F_BTNOVR] = button_override;
  end

  mer_flags #(
    .W (`MER_FLAG_W)
  ) u_flags (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .set_in  (set_v),
    .clr_in  (wr_stat ? reg_wdata[`MER_FLAG_W-1:0] : {`MER_FLAG_W{1'b0}}),
    .flag_r  (flag)
  );

  // override arms ACPI only after the next wake
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_awake_r <= 1'b0;
      enter_s5    <= 1'b0;
    end else begin
      enter_s5 <= button_override;
      if (button_override || !flag[`MER_F_BTNOVR])
        ovr_awake_r <= 1'b0;
      else if (wake_to_s0)
        ovr_awake_r <= 1'b1;
    end
  end

  // PME gated into the general event bank
  wire pme_en  = flag[`MER_F_PME] && gate_r[`MER_G_PME];
  // global gate on every ACPI source except the FWREL flag
  wire acpi_any = (flag[`MER_F_FWREL] && gate_r[`MER_G_FWREL]) ||
                  (acpi_gate && (flag[`MER_F_CPUWD] || pme_en ||
                   (flag[`MER_F_HP] && gate_r[`MER_G_HP_ACPI]) ||
                   (flag[`MER_F_ESPI] && gate_r[`MER_G_ESPI_ACPI]) ||
                   (flag[`MER_F_BTNOVR] && ovr_awake_r)));

  // dual-kind sources only with ACPI gate clear
  wire dual_mgmt = !acpi_gate &&
                   ((flag[`MER_F_HP] && gate_r[`MER_G_HP_MGMT]) ||
                    (flag[`MER_F_ESPI] && gate_r[`MER_G_ESPI_MGMT]));

  // trap sources depend on the management path being enabled
  wire mgmt_src = (flag[`MER_F_OSREL] && gate_r[`MER_G_OSREL]) ||
                  flag[`MER_F_OSWD] || flag[`MER_F_NMI] ||
                  flag[`MER_F_CHAS] || flag[`MER_F_FLASH] ||
                  (flag[`MER_F_PPORT] && gate_r[`MER_G_PPORT]) ||
                  (flag[`MER_F_SLEEP] && gate_r[`MER_G_SLEEP]) ||
                  (flag[`MER_F_PINUNL] && gate_r[`MER_G_PINUNL]) ||
                  flag[`MER_F_IOTRAP] ||
                  (flag[`MER_F_SMB] && !flag[`MER_F_HNOTE]) ||
                  (flag[`MER_F_HNOTE] && gate_r[`MER_G_HNOTE]) ||
                  dual_mgmt;

  wire mgmt_pend = mgmt_gate && mgmt_src;

  localparam ST_FIRED = 1'b0;
  localparam ST_ARMED = 1'b1;

  reg done_nxt;
  reg fire_nxt;

  // fire once, wait for re-arm
  // Hardware clear beats a same-cycle software re-arm so no pulse is lost
  always @* begin
    done_nxt = done_r;
    fire_nxt = 1'b0;
    case (done_r)
      ST_ARMED: begin
        if (mgmt_pend) begin
          done_nxt = ST_FIRED;
          fire_nxt = 1'b1;
        end
      end
      ST_FIRED: begin
        if (wr_ctrl && reg_wdata[`MER_C_DONE])
          done_nxt = ST_ARMED;
      end
      default: begin
        done_nxt = ST_ARMED;
      end
    endcase
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_r              <= ST_ARMED;
      mgmt_mode_interrupt <= 1'b0;
    end else begin
      done_r              <= done_nxt;
      mgmt_mode_interrupt <= fire_nxt;
    end
  end

  // level output from set, enabled flags
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acpi_level_irq <= 1'b0;
      acpi_irq_line  <= 7'h00;
      pme_wake       <= 1'b0;
    end else begin
      acpi_level_irq <= acpi_any;
      acpi_irq_line  <= acpi_any ? line_dec(ctrl_r[`MER_C_ROUTE_HI:`MER_C_ROUTE_LO],
                                            ctrl_r[`MER_C_APIC]) : 7'h00;
      pme_wake       <= pme_en;
    end
  end

  reg [31:0] rd_v;

  always @* begin
    rd_v = 32'h0000_0000;
    case (reg_addr)
      `MER_OFS_CTRL: begin
        rd_v[`MER_CTRL_W-1:0] = ctrl_r;
        rd_v[`MER_C_DONE]     = done_r;
      end
      `MER_OFS_GATE:  rd_v[`MER_GATE_W-1:0] = gate_r;
      `MER_OFS_STAT:  rd_v[`MER_FLAG_W-1:0] = flag;
      `MER_OFS_WDOG:  rd_v[7:0] = wdog_r;
      `MER_OFS_PPORT: rd_v[7:0] = pport_r;
      `MER_OFS_STATE: rd_v[10:0] = {acpi_irq_line, mgmt_pend, done_r,
                                    acpi_level_irq, mgmt_mode_interrupt};
      default:        rd_v = 32'h0000_0000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rd_v;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule // mer_top

`default_nettype wire

// [verification/mer_props.sv]
`timescale 1ns/100ps
`default_nettype none
module mer_props (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        pme_msg,
  input wire logic        button_override,
  input wire logic        mgmt_mode_interrupt,
  input wire logic        acpi_level_irq,
  input wire logic [6:0]  acpi_irq_line,
  input wire logic        enter_s5,
  input wire logic        pme_wake
);
  // Shadow of the control word, so gate checks need no internal probes
  logic [12:0] ctl_r;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r <= 13'h0004;
    end else if (reg_wr && reg_addr == 8'h00) begin
      ctl_r <= reg_wdata[12:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_mgmt_gated: assert property (
    mgmt_mode_interrupt |-> ctl_r[1] || $past(ctl_r[1]) || $past(ctl_r[1], 2))
    else $error("management pulse without global gate");
  a_mgmt_rearm: assert property (
    mgmt_mode_interrupt && !(reg_wr && reg_addr == 8'h00 && reg_wdata[2]) |=>
      !mgmt_mode_interrupt [*2])
    else $error("management pulse repeated without re-arm");
  a_line_level: assert property (
    acpi_level_irq == (acpi_irq_line != 7'h00) && $onehot0(acpi_irq_line))
    else $error("interrupt line vector disagrees with level");
  a_apic_only: assert property (
    |acpi_irq_line[6:3] |-> ctl_r[3] || $past(ctl_r[3]) || $past(ctl_r[3], 2))
    else $error("upper interrupt line used outside apic mode");
  a_acpi_clear: assert property (
    $fell(acpi_level_irq) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(button_override))
    else $error("acpi level dropped without software write");
  a_s5_follows: assert property (
    button_override |=> enter_s5)
    else $error("no s5 entry after button override");
  a_s5_cause: assert property (
    enter_s5 |-> $past(button_override))
    else $error("s5 entry without button override");
  a_wake_cause: assert property (
    $rose(pme_wake) |-> $past(pme_msg) || $past(pme_msg, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("wake without pme message");
endmodule // mer_props
bind mer_top mer_props mer_props_inst (
  .ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .pme_msg, .button_override,
  .mgmt_mode_interrupt, .acpi_level_irq, .acpi_irq_line, .enter_s5, .pme_wake
);
`default_nettype wire

// [verification/mer_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module mer_host_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       mgmt_mode_interrupt,
  input  wire logic       espi_go,
  input  wire logic [4:0] espi_len,
  output wire logic       espi_acpi_req,
  output var  logic [7:0] mgmt_cnt
);
  logic [4:0] left_r;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mgmt_cnt <= 8'h00;
      left_r   <= 5'h00;
    end else begin
      if (mgmt_mode_interrupt) begin
        mgmt_cnt <= mgmt_cnt + 8'h01;
      end
      if (espi_go) begin
        left_r <= espi_len;
      end else if (left_r != 5'h00) begin
        left_r <= left_r - 5'h01;
      end
    end
  end
  assign espi_acpi_req = (left_r != 5'h00);
endmodule // mer_host_model
`default_nettype wire

// [verification/mer_top_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module mer_top_tb_top;
  localparam logic [31:0] B = 32'h0686;
  logic        ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [15:0] pv = 16'h0;
  logic [4:0]  len = 5'h00;
  logic [17:0] ex [0:10] = '{18'h2, 18'h100, 18'h200, 18'h80, 18'h400, 18'h2000,
                             18'h4000, 18'hc000, 18'h80, 18'h30, 18'h40};
  wire  [31:0] reg_rdata;
  wire  [6:0]  acpi_irq_line;
  wire  [7:0]  mgmt_cnt;
  wire         mgmt_mode_interrupt, acpi_level_irq, enter_s5, pme_wake, espi_acpi_req;
  int          errors = 0, tests_run = 0, n = 0, i;

  mer_top #(.ESPI_HOLD_CYC(8)) mer_top_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chassis_open_in_n(!pv[10]),
    .smbus_alert_n(!pv[6]), .espi_acpi_req(espi_acpi_req), .nmi_in(pv[9]), .pme_msg(pv[12]),
    .hotplug_msg(pv[13]), .cpu_watchdog_msg(pv[11]), .io_trap_hit(pv[5]),
    .host_notify_msg(pv[7]), .flash_write_try(pv[8]), .button_override(pv[14]),
    .wake_to_s0(pv[15]), .mgmt_mode_interrupt(mgmt_mode_interrupt),
    .acpi_level_irq(acpi_level_irq), .acpi_irq_line(acpi_irq_line), .enter_s5(enter_s5),
    .pme_wake(pme_wake));
  mer_host_model mer_host_model_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .mgmt_mode_interrupt(mgmt_mode_interrupt),
    .espi_go(go), .espi_len(len), .espi_acpi_req(espi_acpi_req), .mgmt_cnt(mgmt_cnt));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Register causes use the bus, pin causes a one-cycle pulse on the pin vector
  task automatic fire(input int k);
    case (k)
      0: wr(8'h0c, 32'h2);
      1: wr(8'h14, 32'hb2);
      2: wr(8'h0c, 32'h4);
      3: wr(8'h00, B | 32'h800);
      4: begin
        wr(8'h00, B | 32'h1000);
        wr(8'h00, B);
      end
      default: begin
        @(posedge ref_clk);
        pv <= 16'h1 << k;
        @(posedge ref_clk);
        pv <= 16'h0;
      end
    endcase
  endtask
  task automatic clr(input logic [31:0] c);
    wr(8'h08, 32'h3ffff);
    wr(8'h00, c);
  endtask
  task automatic cnt(input int e);
    chk(32'(mgmt_cnt), e);
  endtask

  task automatic t_reset;
    rd(8'h00, 32'h4);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'hfc, 32'h0);
  endtask
  task automatic t_mgmt;
    wr(8'h10, 32'h5a);
    cyc(5);
    cnt(0);
    rd(8'h08, 32'h8);
    wr(8'h00, 32'h6);
    cyc(5);
    cnt(1);
    rd(8'h00, 32'h2);
    wr(8'h00, 32'h6);
    cyc(5);
    cnt(2);
    clr(32'h6);
    cyc(5);
    cnt(2);
    n = 2;
  endtask
  task automatic t_acpi;
    fire(11);
    cyc(4);
    chk(32'(acpi_level_irq), 1'b0);
    rd(8'h08, 32'h4);
    for (i = 0; i < 7; i++) begin
      wr(8'h00, 32'hd | (i << 4));
      cyc(3);
      chk(32'(acpi_irq_line), 7'h1 << i);
    end
    wr(8'h00, 32'h35);
    cyc(3);
    chk(32'(acpi_irq_line), 7'h1);
    cnt(n);
    clr(32'h4);
    cyc(3);
    chk(32'(acpi_level_irq), 1'b0);
    wr(8'h04, 32'h1);
    fire(0);
    wr(8'h0c, 32'h1);
    cyc(3);
    chk(32'(acpi_level_irq), 1'b1);
    rd(8'h08, 32'h3);
  endtask
  task automatic t_src;
    wr(8'h04, 32'h11e);
    clr(B);
    for (i = 0; i <= 10; i++) begin
      fire(i);
      cyc(8);
      rd(8'h08, 32'(ex[i]));
      cnt(++n);
      clr(B);
    end
  endtask
  task automatic t_dual;
    wr(8'h04, 32'h2e0);
    clr(32'h7);
    fire(13);
    cyc(6);
    chk(32'(acpi_level_irq), 1'b1);
    cnt(n);
    chk(32'(pme_wake), 1'b0);
    clr(32'h6);
    fire(13);
    cyc(6);
    cnt(++n);
    clr(32'h5);
    fire(12);
    cyc(6);
    chk(32'(pme_wake), 1'b1);
    rd(8'h08, 32'h800);
    clr(32'h5);
    for (i = 4; i <= 12; i += 8) begin
      @(posedge ref_clk);
      len <= 5'(i);
      go  <= 1'b1;
      @(posedge ref_clk);
      go  <= 1'b0;
      cyc(20);
      chk(32'(acpi_level_irq), i > 8);
    end
    rd(8'h08, 32'h10000);
    clr(32'h5);
  endtask
  task automatic t_btn;
    fire(14);
    #1 chk(32'(enter_s5), 1'b1);
    cyc(4);
    chk(32'(acpi_level_irq), 1'b0);
    fire(15);
    cyc(4);
    chk(32'(acpi_level_irq), 1'b1);
    rd(8'h08, 32'h20000);
  endtask

  task automatic results;
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset();
    t_mgmt();
    t_acpi();
    t_src();
    t_dual();
    t_btn();
    results();
  end
  // Whole run is a few hundred cycles; this span only cuts a hang
  initial begin
    #400000;
    errors++;
    results();
  end
endmodule // mer_top_tb_top
`default_nettype wire
